// [logic/fhp_host_port.sv]
// host port of the floppy controller: registers, strobes, request and interrupt lines
// Functional notes
// - reset low 50 us forces command 03
// - not-ready status bit cleared during reset
// - restore command starts on reset release
// - sector register loads 01 on release
// - select and write strobe capture bus byte
// - select and read strobe drive register
// - code decode: status/command, track, sector, data
// - strobes ignored unless device selected
// - bus driven only during read strobes
// - build option inverts bus both directions
// - request set on byte ready or empty
// - servicing data register drops the request
// - interrupt raised when operation completes
// - interrupt cleared by command write, status read
// - command write-only, status read-only
module fhp_host_port #(
   parameter bit          INVERT_BUS    = 1'b1,
   parameter int unsigned RESET_MIN_CYC = fhp_pkg::RESET_MIN_CYC
) (
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       clk_en,
   input  wire logic       power_on_clear_n,
   input  wire logic       chip_sel_n,
   input  wire logic       output_strobe_n,
   input  wire logic       input_strobe_n,
   input  wire logic       reg_pick_low,
   input  wire logic       reg_pick_high,
   input  wire logic [7:0] host_bus_lines_in,
   output logic      [7:0] host_bus_lines_out,
   output logic      [7:0] host_bus_lines_oe,
   input  wire logic       op_done,
   input  wire logic       op_busy,
   input  wire logic       drive_not_ready,
   input  wire logic [6:0] core_status,
   input  wire logic       core_byte_valid,
   input  wire logic [7:0] core_byte,
   input  wire logic       core_byte_take,
   input  wire logic       xfer_dir_write,
   input  wire logic       xfer_active,
   output logic      [7:0] command_out,
   output logic            command_new,
   output logic            restore_start,
   output logic      [7:0] track_out,
   output logic      [7:0] sector_out,
   output logic      [7:0] hold_buffer_out,
   output logic            reset_long_enough,
   output logic            xfer_req,
   output logic            xfer_req_oe,
   output logic            irq_line,
   output logic            irq_line_oe
);
   // ---------------------------------------------------------------
   // parameter checks
   // ---------------------------------------------------------------
   if (RESET_MIN_CYC < 1) begin : g_bad_reset_cyc
      $error("reset hold count must be at least one cycle");
   end

   // ---------------------------------------------------------------
   // reset release and pin synchronisers
   // ---------------------------------------------------------------
   logic       rst_s1_ff;
   logic       rst_s2_ff;
   logic [4:0] pin_s1_ff;
   logic [4:0] pin_s2_ff;
   logic [7:0] bus_s1_ff;
   logic [7:0] bus_s2_ff;
   logic       pc_s1_ff;
   logic       pc_s2_ff;
   logic       pc_prev_ff;
   wire logic  rst_n = rst_s2_ff;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_ff <= 1'b0;
         rst_s2_ff <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_s2_ff <= rst_s1_ff;
      end
   end

   // strobes pass two flops before any side effect
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_ff <= 5'h1F;
         pin_s2_ff <= 5'h1F;
         bus_s1_ff <= 8'h00;
         bus_s2_ff <= 8'h00;
         pc_s1_ff  <= 1'b0;
         pc_s2_ff  <= 1'b0;
      end else if (clk_en) begin
         pin_s1_ff <= {chip_sel_n, output_strobe_n, input_strobe_n, reg_pick_high, reg_pick_low};
         pin_s2_ff <= pin_s1_ff;
         bus_s1_ff <= host_bus_lines_in;
         bus_s2_ff <= bus_s1_ff;
         pc_s1_ff  <= power_on_clear_n;
         pc_s2_ff  <= pc_s1_ff;
      end
   end

   fhp_pkg::fhp_strobe_s stb;
   always_comb begin
      stb.sel  = ~pin_s2_ff[4];
      stb.rd   = stb.sel & ~pin_s2_ff[3];
      stb.wr   = stb.sel & ~pin_s2_ff[2] & pin_s2_ff[3];
      stb.addr = pin_s2_ff[1:0];
   end

   // bus byte as seen inside, polarity per build option
   logic [7:0] bus_in_true;
   assign bus_in_true = INVERT_BUS ? ~bus_s2_ff : bus_s2_ff;

   // edge detection on synchronised strobes
   logic rd_prev_ff;
   logic wr_prev_ff;
   logic rd_end;
   logic wr_rise;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rd_prev_ff <= 1'b0;
         wr_prev_ff <= 1'b0;
         pc_prev_ff <= 1'b0;
      end else if (clk_en) begin
         rd_prev_ff <= stb.rd;
         wr_prev_ff <= stb.wr;
         pc_prev_ff <= pc_s2_ff;
      end
   end
   // read side effects act when the strobe ends so the byte is not lost mid-read
   assign rd_end  = rd_prev_ff & ~stb.rd;
   assign wr_rise = stb.wr & ~wr_prev_ff;

   logic [1:0] rd_addr_ff;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rd_addr_ff <= 2'h0;
      end else if (clk_en && stb.rd) begin
         rd_addr_ff <= stb.addr;
      end
   end

   // ---------------------------------------------------------------
   // master reset hold timer
   // ---------------------------------------------------------------
   logic        pc_active;
   logic [31:0] pc_cnt_ff;
   logic        restore_ff;
   assign pc_active = ~pc_s2_ff;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pc_cnt_ff <= 32'h0;
      end else if (clk_en) begin
         if (!pc_active) begin
            pc_cnt_ff <= 32'h0;
         end else if (pc_cnt_ff < RESET_MIN_CYC) begin
            pc_cnt_ff <= pc_cnt_ff + 32'h1;
         end
      end
   end
   assign reset_long_enough = (pc_cnt_ff >= RESET_MIN_CYC);

   // ---------------------------------------------------------------
   // command register
   // ---------------------------------------------------------------
   logic [7:0] command_ff;
   logic       command_new_ff;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         command_ff     <= fhp_pkg::CMD_RESET_VAL;
         command_new_ff <= 1'b0;
      end else if (clk_en) begin
         command_new_ff <= 1'b0;
         if (pc_active) begin
            command_ff <= fhp_pkg::CMD_RESET_VAL;
         end else if (wr_rise && stb.addr == fhp_pkg::SEL_STAT_CMD) begin
            command_ff     <= bus_in_true;
            command_new_ff <= 1'b1;
         end
      end
   end
   assign command_out = command_ff;
   assign command_new = command_new_ff;

   // restore pulse on release, drive ready not consulted
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         restore_ff <= 1'b0;
      end else if (clk_en) begin
         restore_ff <= pc_s2_ff & ~pc_prev_ff;
      end
   end
   assign restore_start = restore_ff;

   // ---------------------------------------------------------------
   // track and sector registers
   // ---------------------------------------------------------------
   logic [7:0] track_ff;
   logic [7:0] sector_ff;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         track_ff <= fhp_pkg::ZERO_BYTE;
      end else if (clk_en && !pc_active && wr_rise && stb.addr == fhp_pkg::SEL_TRACK) begin
         track_ff <= bus_in_true;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sector_ff <= fhp_pkg::SECT_RESET_VAL;
      end else if (clk_en) begin
         if (pc_s2_ff && !pc_prev_ff) begin
            sector_ff <= fhp_pkg::SECT_RESET_VAL;
         end else if (!pc_active && wr_rise && stb.addr == fhp_pkg::SEL_SECTOR) begin
            sector_ff <= bus_in_true;
         end
      end
   end
   assign track_out  = track_ff;
   assign sector_out = sector_ff;

   // ---------------------------------------------------------------
   // data holding register and transfer request
   // ---------------------------------------------------------------
   logic [7:0] hold_ff;
   logic       req_ff;
   logic       data_wr;
   logic       data_rd;
   assign data_wr = wr_rise && stb.addr == fhp_pkg::SEL_DATA && !pc_active;
   assign data_rd = rd_end && rd_addr_ff == fhp_pkg::SEL_DATA && !pc_active;

   // core load and host write share the holder; core wins as it cannot wait
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hold_ff <= fhp_pkg::ZERO_BYTE;
      end else if (clk_en) begin
         if (core_byte_valid && !xfer_dir_write) begin
            hold_ff <= core_byte;
         end else if (data_wr) begin
            hold_ff <= bus_in_true;
         end
      end
   end
   assign hold_buffer_out = hold_ff;

   // set wins over service in the same cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         req_ff <= 1'b0;
      end else if (clk_en) begin
         if (pc_active || !xfer_active) begin
            req_ff <= 1'b0;
         end else if ((!xfer_dir_write && core_byte_valid) || (xfer_dir_write && core_byte_take)) begin
            req_ff <= 1'b1;
         end else if ((!xfer_dir_write && data_rd) || (xfer_dir_write && data_wr)) begin
            req_ff <= 1'b0;
         end
      end
   end
   // open drain: pull low when idle, release when asserted
   assign xfer_req    = 1'b0;
   assign xfer_req_oe = ~req_ff;

   // ---------------------------------------------------------------
   // interrupt request
   // ---------------------------------------------------------------
   logic irq_ff;
   logic stat_rd;
   assign stat_rd = rd_end && rd_addr_ff == fhp_pkg::SEL_STAT_CMD;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_ff <= 1'b0;
      end else if (clk_en) begin
         if (pc_active) begin
            irq_ff <= 1'b0;
         end else if (op_done) begin
            irq_ff <= 1'b1;
         end else if (command_new_ff || stat_rd) begin
            irq_ff <= 1'b0;
         end
      end
   end
   assign irq_line    = 1'b0;
   assign irq_line_oe = ~irq_ff;

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   logic [7:0] status_val;
   logic [7:0] rd_mux;
   logic [7:0] bus_out_ff;
   logic       bus_oe_ff;
   always_comb begin
      status_val                          = {1'b0, core_status};
      status_val[fhp_pkg::STAT_NRDY_BIT]  = drive_not_ready & ~pc_active;
      status_val[fhp_pkg::STAT_BUSY_BIT]  = op_busy | core_status[fhp_pkg::STAT_BUSY_BIT];
      unique case (stb.addr)
         fhp_pkg::SEL_STAT_CMD: rd_mux = status_val;
         fhp_pkg::SEL_TRACK:    rd_mux = track_ff;
         fhp_pkg::SEL_SECTOR:   rd_mux = sector_ff;
         fhp_pkg::SEL_DATA:     rd_mux = hold_ff;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bus_out_ff <= 8'h00;
         bus_oe_ff  <= 1'b0;
      end else if (clk_en) begin
         bus_oe_ff  <= stb.rd;
         bus_out_ff <= INVERT_BUS ? ~rd_mux : rd_mux;
      end
   end
   assign host_bus_lines_out = bus_out_ff;
   assign host_bus_lines_oe  = {8{bus_oe_ff}};

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   bus_drive_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en |=> (host_bus_lines_oe[0] == $past(stb.rd)))
      else $error("bus drive does not follow read strobe");
   cmd_reset_val_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (clk_en && pc_active) |=> command_out == 8'h03)
      else $error("command not forced during master reset");
   sector_release_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (clk_en && pc_s2_ff && !pc_prev_ff) |=> sector_out == 8'h01)
      else $error("sector not loaded on release");
   restore_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (clk_en && pc_s2_ff && !pc_prev_ff) |=> restore_start ##1 (!restore_start || !$past(clk_en)))
      else $error("restore not started on release");
   irq_set_done_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (clk_en && op_done && !pc_active) |=> !irq_line_oe)
      else $error("interrupt not raised on completion");
   irq_clear_stat_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (clk_en && stat_rd && !op_done && !pc_active) |=> irq_line_oe)
      else $error("interrupt not cleared by status read");
   notready_reset_a: assert property (@(posedge mclk) disable iff (!rst_n)
      pc_active |-> !status_val[7])
      else $error("not ready shown during reset");
   req_service_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (clk_en && xfer_active && !xfer_dir_write && data_rd && !core_byte_valid && !pc_active)
      |=> xfer_req_oe)
      else $error("request not dropped after service");
   unselected_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (clk_en && pin_s2_ff[4]) |=> !host_bus_lines_oe[0])
      else $error("bus driven while not selected");
endmodule : fhp_host_port

// [logic/fhp_pkg.sv]
// package for the floppy controller host port: register codes, reset values, timing
package fhp_pkg;
   // ---------------------------------------------------------------
   // register select codes
   // ---------------------------------------------------------------
   localparam logic [1:0] SEL_STAT_CMD = 2'h0;
   localparam logic [1:0] SEL_TRACK    = 2'h1;
   localparam logic [1:0] SEL_SECTOR   = 2'h2;
   localparam logic [1:0] SEL_DATA     = 2'h3;
   // ---------------------------------------------------------------
   // reset values and field positions
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_RESET_VAL  = 8'h03;
   localparam logic [7:0] SECT_RESET_VAL = 8'h01;
   localparam logic [7:0] ZERO_BYTE      = 8'h00;
   localparam int         STAT_NRDY_BIT  = 7;
   localparam int         STAT_BUSY_BIT  = 0;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ         = 200;
   localparam int RESET_MIN_US    = 50;
   localparam int RESET_MIN_CYC   = RESET_MIN_US * CLK_MHZ;
   localparam int CORE_CLK_KHZ    = 1000;
   localparam int CORE_DIV_CYC    = (CLK_MHZ * 1000) / CORE_CLK_KHZ;
   // ---------------------------------------------------------------
   // grouped bus strobes after synchronising
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       sel;
      logic       rd;
      logic       wr;
      logic [1:0] addr;
   } fhp_strobe_s;
endpackage : fhp_pkg

// [sim/fhp_host_model.sv]
// host processor model that drives the floppy controller host port bus
module fhp_host_model #(
   parameter bit INVERT_BUS = 1'b1
) (
   input  wire logic       mclk,
   output logic            chip_sel_n,
   output logic            output_strobe_n,
   output logic            input_strobe_n,
   output logic            reg_pick_low,
   output logic            reg_pick_high,
   output logic      [7:0] host_bus_lines_in,
   input  wire logic [7:0] host_bus_lines_out,
   input  wire logic [7:0] host_bus_lines_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // pins and resolved bus
   // ---------------------------------------------------------------
   fhp_pkg::fhp_strobe_s req;
   logic [7:0]           drv;
   logic [7:0]           last_ff;
   initial req = '0;
   initial drv = 8'h00;
   initial last_ff = 8'h00;
   assign chip_sel_n      = ~req.sel;
   assign output_strobe_n = ~req.rd;
   assign input_strobe_n  = ~req.wr;
   assign reg_pick_low    = req.addr[0];
   assign reg_pick_high   = req.addr[1];
   // undriven lines show the inverse of the last level, so stale data never passes as a match
   assign host_bus_lines_in = (host_bus_lines_oe & host_bus_lines_out) | (~host_bus_lines_oe & (req.wr ? drv : ~last_ff));
   always @(posedge mclk) last_ff <= host_bus_lines_in;
   // ---------------------------------------------------------------
   // bus cycles, one strobe at a time, spaced by idle cycles
   // ---------------------------------------------------------------
   task automatic write_reg(input logic [1:0] sel, input logic [7:0] value, input logic gate);
      @(negedge mclk);
      drv = INVERT_BUS ? ~value : value;
      req = '{sel: gate, rd: 1'b0, wr: 1'b1, addr: sel};
      repeat (5) @(negedge mclk);
      req = '0;
      repeat (4) @(negedge mclk);
   endtask : write_reg
   task automatic read_reg(input logic [1:0] sel, output logic [7:0] value);
      int n;
      value = 8'hXX;
      n = 0;
      @(negedge mclk);
      req = '{sel: 1'b1, rd: 1'b1, wr: 1'b0, addr: sel};
      while (n < 8) begin
         @(negedge mclk);
         n++;
         if (host_bus_lines_oe === 8'hFF) begin
            value = INVERT_BUS ? ~host_bus_lines_out : host_bus_lines_out;
            n = 8;
         end
      end
      req = '0;
      repeat (4) @(negedge mclk);
   endtask : read_reg
endmodule : fhp_host_model

// [sim/test_floppy_ctrl_host_port.sv]
// self-checking bench for the floppy controller host port
module test_floppy_ctrl_host_port;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // signals and instances
   // ---------------------------------------------------------------
   localparam int unsigned RST_CYC = 20; // short master reset count keeps the run brief
   logic       mclk, rst_b, clk_en, power_on_clear_n, chip_sel_n, output_strobe_n, input_strobe_n;
   logic       reg_pick_low, reg_pick_high, op_done, op_busy, drive_not_ready, core_byte_valid;
   logic       core_byte_take, xfer_dir_write, xfer_active, command_new, restore_start;
   logic       reset_long_enough, xfer_req, xfer_req_oe, irq_line, irq_line_oe;
   logic [7:0] host_bus_lines_in, host_bus_lines_out, host_bus_lines_oe, core_byte;
   logic [7:0] command_out, track_out, sector_out, hold_buffer_out, rd;
   logic [6:0] core_status;
   int         n_fail, tests_run, n_cmd;
   fhp_host_port #(.INVERT_BUS(1'b1), .RESET_MIN_CYC(RST_CYC)) u_dut (
      .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .power_on_clear_n(power_on_clear_n),
      .chip_sel_n(chip_sel_n), .output_strobe_n(output_strobe_n), .input_strobe_n(input_strobe_n),
      .reg_pick_low(reg_pick_low), .reg_pick_high(reg_pick_high), .host_bus_lines_in(host_bus_lines_in),
      .host_bus_lines_out(host_bus_lines_out), .host_bus_lines_oe(host_bus_lines_oe), .op_done(op_done),
      .op_busy(op_busy), .drive_not_ready(drive_not_ready), .core_status(core_status),
      .core_byte_valid(core_byte_valid), .core_byte(core_byte), .core_byte_take(core_byte_take),
      .xfer_dir_write(xfer_dir_write), .xfer_active(xfer_active), .command_out(command_out),
      .command_new(command_new), .restore_start(restore_start), .track_out(track_out),
      .sector_out(sector_out), .hold_buffer_out(hold_buffer_out), .reset_long_enough(reset_long_enough),
      .xfer_req(xfer_req), .xfer_req_oe(xfer_req_oe), .irq_line(irq_line), .irq_line_oe(irq_line_oe));
   fhp_host_model #(.INVERT_BUS(1'b1)) u_host (
      .mclk(mclk), .chip_sel_n(chip_sel_n), .output_strobe_n(output_strobe_n),
      .input_strobe_n(input_strobe_n), .reg_pick_low(reg_pick_low), .reg_pick_high(reg_pick_high),
      .host_bus_lines_in(host_bus_lines_in), .host_bus_lines_out(host_bus_lines_out),
      .host_bus_lines_oe(host_bus_lines_oe));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // command strobe count, seen at the falling edge while it stands
   always @(negedge mclk) begin
      if (command_new === 1'b1) begin
         n_cmd++;
      end
   end
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict
   task automatic pulse(ref logic s);
      @(negedge mclk);
      s = 1'b1;
      @(negedge mclk);
      s = 1'b0;
      repeat (3) @(negedge mclk);
   endtask : pulse
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      check(command_out, fhp_pkg::CMD_RESET_VAL, "command at reset");
      check(sector_out, fhp_pkg::SECT_RESET_VAL, "sector at reset");
      check(host_bus_lines_oe, 8'h00, "bus idle");
      u_host.read_reg(fhp_pkg::SEL_SECTOR, rd);
      check(rd, 8'h01, "sector read at reset");
   endtask : t_reset
   task automatic t_regs();
      logic [7:0] vals [3];
      vals = '{8'h5A, 8'hA5, 8'h3C};
      for (int i = 1; i < 4; i++) begin
         u_host.write_reg(2'(i), vals[i-1], 1'b1);
         u_host.read_reg(2'(i), rd);
         check(rd, vals[i-1], "register read back");
      end
      check(track_out, 8'h5A, "track register");
      check(sector_out, 8'hA5, "sector register");
      check(hold_buffer_out, 8'h3C, "data register");
      u_host.write_reg(fhp_pkg::SEL_TRACK, 8'hFF, 1'b0);
      check(track_out, 8'h5A, "unselected write ignored");
      check(host_bus_lines_oe, 8'h00, "bus released");
   endtask : t_regs
   task automatic t_status();
      drive_not_ready = 1'b1;
      core_status = 7'h2A;
      u_host.write_reg(fhp_pkg::SEL_STAT_CMD, 8'h55, 1'b1);
      check(command_out, 8'h55, "command written");
      u_host.read_reg(fhp_pkg::SEL_STAT_CMD, rd);
      check(rd, 8'hAA, "status not command on read");
   endtask : t_status
   task automatic t_irq();
      pulse(op_done);
      check({7'h00, irq_line_oe}, 8'h00, "irq raised");
      u_host.read_reg(fhp_pkg::SEL_STAT_CMD, rd);
      check({7'h00, irq_line_oe}, 8'h01, "irq cleared by status read");
      pulse(op_done);
      check({7'h00, irq_line_oe}, 8'h00, "irq raised again");
      u_host.write_reg(fhp_pkg::SEL_STAT_CMD, 8'h10, 1'b1);
      check({7'h00, irq_line_oe}, 8'h01, "irq cleared by command");
      check(8'(n_cmd), 8'h02, "command strobes");
      clk_en = 1'b0;
      pulse(op_done);
      check({7'h00, irq_line_oe}, 8'h01, "irq held while frozen");
      clk_en = 1'b1;
   endtask : t_irq
   task automatic t_xfer_req();
      xfer_active = 1'b1;
      xfer_dir_write = 1'b0;
      core_byte = 8'hC3;
      pulse(core_byte_valid);
      check({7'h00, xfer_req_oe}, 8'h00, "request on read byte");
      check({6'h00, xfer_req, irq_line}, 8'h00, "open drain low level");
      u_host.read_reg(fhp_pkg::SEL_DATA, rd);
      check(rd, 8'hC3, "polled data byte");
      check({7'h00, xfer_req_oe}, 8'h01, "request dropped by read");
      xfer_dir_write = 1'b1;
      pulse(core_byte_take);
      check({7'h00, xfer_req_oe}, 8'h00, "request on empty buffer");
      u_host.write_reg(fhp_pkg::SEL_DATA, 8'h7E, 1'b1);
      check({7'h00, xfer_req_oe}, 8'h01, "request dropped by write");
      check(hold_buffer_out, 8'h7E, "written data byte");
      xfer_active = 1'b0;
   endtask : t_xfer_req
   task automatic t_master_reset();
      int n;
      @(negedge mclk);
      power_on_clear_n = 1'b0;
      repeat (RST_CYC + 5) @(negedge mclk);
      check({7'h00, reset_long_enough}, 8'h01, "reset long enough");
      check(command_out, fhp_pkg::CMD_RESET_VAL, "command forced");
      u_host.read_reg(fhp_pkg::SEL_STAT_CMD, rd);
      check({7'h00, rd[fhp_pkg::STAT_NRDY_BIT]}, 8'h00, "not ready cleared");
      power_on_clear_n = 1'b1;
      n = 0;
      while (n < 10 && restore_start !== 1'b1) begin
         @(negedge mclk);
         n++;
      end
      check({7'h00, restore_start}, 8'h01, "restore started");
      check(sector_out, fhp_pkg::SECT_RESET_VAL, "sector reloaded");
   endtask : t_master_reset
   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      {rst_b, op_done, op_busy, drive_not_ready, core_byte_valid, core_byte_take} = 6'h00;
      {xfer_dir_write, xfer_active, core_status, core_byte} = 17'h00000;
      {clk_en, power_on_clear_n} = 2'h3;
      n_fail = 0;
      tests_run = 0;
      n_cmd = 0;
      repeat (3) @(negedge mclk);
      rst_b = 1'b1;
      repeat (4) @(negedge mclk);
      t_reset();
      t_regs();
      t_status();
      t_irq();
      t_xfer_req();
      t_master_reset();
      print_verdict();
   end
   initial begin
      #(5000 * 5);
      n_fail++;
      print_verdict();
   end
endmodule : test_floppy_ctrl_host_port
